// ===== include/mpi_pkg.sv
// Constants, register map, vector table and state codes of the masked priority interrupt unit.
package mpi_pkg;
  // Source counts: fourteen maskable sources plus the software break instruction.
  localparam int MPI_NUM_SRC = 14;
  localparam int MPI_NUM_EXT = 4;
  localparam int MPI_WIN_W = 4;
  localparam int MPI_NUM_EVT = 2;
  // Sources fed from external pins, by request bit index.
  localparam int MPI_EXT_IDX [0:MPI_NUM_EXT-1] = '{4, 8, 11, 12};
  // Byte offsets of the word registers.
  localparam logic [7:0] MPI_OFS_REQ = 8'h00;
  localparam logic [7:0] MPI_OFS_EN = 8'h04;
  localparam logic [7:0] MPI_OFS_CTRL = 8'h08;
  localparam logic [7:0] MPI_OFS_EDGE = 8'h0C;
  localparam logic [7:0] MPI_OFS_ISTAT = 8'h10;
  localparam logic [7:0] MPI_OFS_ICLR = 8'h14;
  localparam logic [7:0] MPI_OFS_IENA = 8'h18;
  localparam logic [7:0] MPI_OFS_STATE = 8'h1C;
  // Field positions.
  localparam int MPI_CTRL_DIS_BIT = 0;
  localparam int MPI_EVT_ACCEPT_BIT = 0;
  localparam int MPI_EVT_BREAK_BIT = 1;
  // Reset values.
  localparam logic [MPI_NUM_SRC-1:0] MPI_REQ_RST = 14'h0000;
  localparam logic [MPI_NUM_SRC-1:0] MPI_EN_RST = 14'h0000;
  localparam logic MPI_DIS_RST = 1'b1;
  localparam logic [MPI_NUM_EXT-1:0] MPI_EDGE_RST = 4'h0;
  localparam logic [MPI_NUM_EVT-1:0] MPI_EVT_RST = 2'h0;
  // Low byte address of each two-byte vector entry, highest priority first.
  localparam logic [15:0] MPI_VEC_LO [0:MPI_NUM_SRC-1] = '{
    16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE,
    16'hFFEC, 16'hFFEA, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE};
  localparam logic [15:0] MPI_VEC_BRK = 16'hFFDC;
  // Stack items pushed on acceptance.
  localparam logic [1:0] MPI_PUSH_PCH = 2'h0;
  localparam logic [1:0] MPI_PUSH_PCL = 2'h1;
  localparam logic [1:0] MPI_PUSH_PS = 2'h2;
  // Acceptance sequencer states.
  typedef enum logic [5:0] {
    MPI_ST_IDLE = 6'h01,
    MPI_ST_PCH = 6'h02,
    MPI_ST_PCL = 6'h04,
    MPI_ST_PS = 6'h08,
    MPI_ST_VLO = 6'h10,
    MPI_ST_VHI = 6'h20
  } mpi_state_e;
endpackage

// ===== rtl/mpi_unit.sv
// Masked priority interrupt unit with AHB-Lite register access and acceptance sequencer.
`timescale 1ns/10ps
module mpi_unit #(
  parameter int NUM_SRC = mpi_pkg::MPI_NUM_SRC
) (
  // Clock and reset.
  input wire logic MCLK_IN,
  input wire logic RST_B_IN,
  // AHB-Lite slave.
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Source events, one-cycle pulses from same-clock logic.
  input wire logic [mpi_pkg::MPI_NUM_SRC-1:0] SRC_EVENT_IN,
  input wire logic SOFTWARE_BREAK_INSTRUCTION_IN,
  output logic [mpi_pkg::MPI_NUM_EXT-1:0] EDGE_SEL_OUT,
  // Processor core.
  input wire logic CORE_ACK_IN,
  output logic CORE_IRQ_OUT,
  output logic PUSH_STB_OUT,
  output logic [1:0] PUSH_ITEM_OUT,
  output logic VEC_RD_STB_OUT,
  output logic [15:0] VEC_ADDR_OUT,
  // Interrupt line.
  output logic INT_OUT
);
  import mpi_pkg::*;

  // The vector table and external mapping are sized for the documented source count.
  // Other counts are refused when the design is elaborated.
  if (NUM_SRC != MPI_NUM_SRC) begin : g_bad_num_src
    $error("NUM_SRC must match the vector table size");
  end

  mpi_state_e state_q, state_d;
  logic [MPI_NUM_SRC-1:0] req_q, req_d, en_q, en_d, qual, req_clr, req_set;
  logic [MPI_NUM_EXT-1:0] edge_q, edge_d;
  logic [MPI_NUM_EVT-1:0] ist_q, ist_d, iena_q, iena_d, evt;
  logic dis_q, dis_d, brk_q, brk_d;
  logic [MPI_WIN_W-1:0] win_q, win_d, sel;
  logic win_brk_q, win_brk_d;
  logic [15:0] vec_q, vec_d;
  logic a_act_q, a_act_d, a_wr_q, a_wr_d;
  logic [7:0] a_ofs_q, a_ofs_d;
  logic any_req, accept, wr_req, wr_en, wr_ctrl, wr_edge, wr_iclr, wr_iena;

  // Address phase capture; the slave never inserts wait states.
  always_comb begin
    a_act_d = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    a_wr_d = HWRITE_IN;
    a_ofs_d = HADDR_IN[7:0];
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      a_act_q <= 1'b0;
      a_wr_q <= 1'b0;
      a_ofs_q <= 8'h00;
    end else begin
      a_act_q <= a_act_d;
      a_wr_q <= a_wr_d;
      a_ofs_q <= a_ofs_d;
    end
  end

  // Data phase write strobes.
  assign wr_req = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_REQ);
  assign wr_en = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_EN);
  assign wr_ctrl = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_CTRL);
  assign wr_edge = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_EDGE);
  assign wr_iclr = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_ICLR);
  assign wr_iena = a_act_q & a_wr_q & (a_ofs_q == MPI_OFS_IENA);
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  // Read mux is combinational so a read right after a write sees the new value.
  always_comb begin
    HRDATA_OUT = 32'h0000_0000;
    if (a_act_q && !a_wr_q) begin
      unique case (a_ofs_q)
        MPI_OFS_REQ: HRDATA_OUT[MPI_NUM_SRC-1:0] = req_q;
        MPI_OFS_EN: HRDATA_OUT[MPI_NUM_SRC-1:0] = en_q;
        MPI_OFS_CTRL: HRDATA_OUT[MPI_CTRL_DIS_BIT] = dis_q;
        MPI_OFS_EDGE: HRDATA_OUT[MPI_NUM_EXT-1:0] = edge_q;
        MPI_OFS_ISTAT: HRDATA_OUT[MPI_NUM_EVT-1:0] = ist_q;
        MPI_OFS_IENA: HRDATA_OUT[MPI_NUM_EVT-1:0] = iena_q;
        MPI_OFS_STATE: HRDATA_OUT[15:0] = {win_brk_q, 3'h0, win_q, 2'h0, state_q};
        default: HRDATA_OUT = 32'h0000_0000;
      endcase
    end
  end

  // Qualification and fixed priority; lowest index is the highest priority.
  always_comb begin
    qual = req_q & en_q & {MPI_NUM_SRC{~dis_q}};
    sel = '0;
    for (int i = MPI_NUM_SRC - 1; i >= 0; i--) begin
      if (qual[i]) begin
        sel = MPI_WIN_W'(i);
      end
    end
  end

  // The break is qualified by nothing, so the disable flag cannot hold it off.
  assign any_req = (|qual) | brk_q;
  assign CORE_IRQ_OUT = any_req & (state_q == MPI_ST_IDLE);
  assign accept = CORE_IRQ_OUT & CORE_ACK_IN;

  // Request, enable, disable, edge and break next values; a set always beats a clear.
  always_comb begin
    req_set = SRC_EVENT_IN;
    req_clr = '0;
    for (int j = 0; j < MPI_NUM_EXT; j++) begin
      if (wr_edge && (HWDATA_IN[j] != edge_q[j])) begin
        req_set[MPI_EXT_IDX[j]] = 1'b1;
      end
    end
    if (wr_req) begin
      req_clr = ~HWDATA_IN[MPI_NUM_SRC-1:0];
    end
    if (accept && !(|qual) == 1'b0) begin
      req_clr[sel] = 1'b1;
    end
    req_d = req_set | (req_q & ~req_clr);
    en_d = wr_en ? HWDATA_IN[MPI_NUM_SRC-1:0] : en_q;
    edge_d = wr_edge ? HWDATA_IN[MPI_NUM_EXT-1:0] : edge_q;
    dis_d = dis_q;
    if (wr_ctrl) begin
      dis_d = HWDATA_IN[MPI_CTRL_DIS_BIT];
    end
    if (accept) begin
      dis_d = 1'b1;
    end
    brk_d = SOFTWARE_BREAK_INSTRUCTION_IN | (brk_q & ~(accept & ~(|qual)));
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      req_q <= MPI_REQ_RST;
      en_q <= MPI_EN_RST;
      dis_q <= MPI_DIS_RST;
      edge_q <= MPI_EDGE_RST;
      brk_q <= 1'b0;
    end else begin
      req_q <= req_d;
      en_q <= en_d;
      dis_q <= dis_d;
      edge_q <= edge_d;
      brk_q <= brk_d;
    end
  end

  assign EDGE_SEL_OUT = edge_q;

  // Acceptance sequencer: stack pushes first, then the two vector byte reads.
  always_comb begin
    state_d = state_q;
    win_d = win_q;
    win_brk_d = win_brk_q;
    vec_d = vec_q;
    unique case (state_q)
      MPI_ST_IDLE: begin
        if (accept) begin
          win_d = sel;
          win_brk_d = ~(|qual);
          state_d = MPI_ST_PCH;
        end
      end
      MPI_ST_PCH: state_d = MPI_ST_PCL;
      MPI_ST_PCL: state_d = MPI_ST_PS;
      MPI_ST_PS: begin
        vec_d = win_brk_q ? MPI_VEC_BRK : MPI_VEC_LO[win_q];
        state_d = MPI_ST_VLO;
      end
      MPI_ST_VLO: begin
        vec_d = 16'(vec_q + 16'h0001);
        state_d = MPI_ST_VHI;
      end
      MPI_ST_VHI: state_d = MPI_ST_IDLE;
      default: state_d = MPI_ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      state_q <= MPI_ST_IDLE;
      win_q <= '0;
      win_brk_q <= 1'b0;
      vec_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      win_q <= win_d;
      win_brk_q <= win_brk_d;
      vec_q <= vec_d;
    end
  end

  // Core side strobes decoded from the one-hot state.
  always_comb begin
    PUSH_STB_OUT = (state_q == MPI_ST_PCH) | (state_q == MPI_ST_PCL) | (state_q == MPI_ST_PS);
    PUSH_ITEM_OUT = MPI_PUSH_PCH;
    if (state_q == MPI_ST_PCL) begin
      PUSH_ITEM_OUT = MPI_PUSH_PCL;
    end
    if (state_q == MPI_ST_PS) begin
      PUSH_ITEM_OUT = MPI_PUSH_PS;
    end
    VEC_RD_STB_OUT = (state_q == MPI_ST_VLO) | (state_q == MPI_ST_VHI);
  end

  assign VEC_ADDR_OUT = vec_q;

  // Sticky event status, enable mask and write-only clear; new events beat clears.
  always_comb begin
    evt = '0;
    evt[MPI_EVT_ACCEPT_BIT] = accept;
    evt[MPI_EVT_BREAK_BIT] = accept & ~(|qual);
    ist_d = evt | (ist_q & ~(wr_iclr ? HWDATA_IN[MPI_NUM_EVT-1:0] : MPI_EVT_RST));
    iena_d = wr_iena ? HWDATA_IN[MPI_NUM_EVT-1:0] : iena_q;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      ist_q <= MPI_EVT_RST;
      iena_q <= MPI_EVT_RST;
    end else begin
      ist_q <= ist_d;
      iena_q <= iena_d;
    end
  end

  assign INT_OUT = |(ist_q & iena_q);

  // Checks on the masking, priority and acceptance behaviour.
  property p_mask;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    CORE_IRQ_OUT && !brk_q |-> (|(req_q & en_q)) && !dis_q;
  endproperty
  a_mask: assert property (p_mask) else $error("request raised without qualification");

  property p_block;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    dis_q && !brk_q |-> !CORE_IRQ_OUT;
  endproperty
  a_block: assert property (p_block) else $error("disable flag did not block");

  property p_brk;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    brk_q && state_q == MPI_ST_IDLE |-> CORE_IRQ_OUT;
  endproperty
  a_brk: assert property (p_brk) else $error("break request suppressed");

  property p_accept;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    accept |=> dis_q && state_q == MPI_ST_PCH;
  endproperty
  a_accept: assert property (p_accept) else $error("acceptance did not set disable");

  property p_seq;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    accept |=> PUSH_STB_OUT [*3] ##1 VEC_RD_STB_OUT [*2] ##1 !VEC_RD_STB_OUT;
  endproperty
  a_seq: assert property (p_seq) else $error("push then vector order broken");

  property p_vec;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    state_q == MPI_ST_VLO |-> ##1 VEC_ADDR_OUT == 16'($past(VEC_ADDR_OUT) + 16'h0001);
  endproperty
  a_vec: assert property (p_vec) else $error("vector high byte address wrong");

  property p_prio;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    accept && qual[0] && qual[1] |=> win_q == 4'h0 && !win_brk_q && req_q[1];
  endproperty
  a_prio: assert property (p_prio) else $error("priority order violated");

  property p_noset;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    $rose(req_q[0]) |-> $past(SRC_EVENT_IN[0]);
  endproperty
  a_noset: assert property (p_noset) else $error("request set without its event");

  property p_hold;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    $fell(req_q[0]) |-> $past(wr_req) || $past(accept);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped without a clear");

  property p_en;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    wr_en |=> en_q == $past(HWDATA_IN[MPI_NUM_SRC-1:0]);
  endproperty
  a_en: assert property (p_en) else $error("enable write not stored");

  property p_edge;
    @(posedge MCLK_IN) disable iff (!RST_B_IN)
    wr_edge && HWDATA_IN[0] != edge_q[0] |=> req_q[4];
  endproperty
  a_edge: assert property (p_edge) else $error("edge change did not set request");
endmodule

// ===== tb/mpi_core_model.sv
// Behavioural processor core that takes interrupts and logs each acceptance.
`timescale 1ns/10ps
module mpi_core_model (
  // Clock.
  input wire logic clk_in,
  // Interrupt link.
  input wire logic irq_in,
  input wire logic take_in,
  input wire logic push_stb_in,
  input wire logic [1:0] push_item_in,
  input wire logic vec_stb_in,
  input wire logic [15:0] vec_addr_in,
  output logic ack_out,
  // Log.
  output logic [15:0] vec_lo_out,
  output int push_cnt_out,
  output int vec_cnt_out
);
  logic hi_next = 1'b0;

  initial begin
    ack_out = 1'b0;
    vec_lo_out = 16'h0000;
    push_cnt_out = 0;
    vec_cnt_out = 0;
  end

  // Acknowledge once at a boundary; take_in low keeps the core from acknowledging at all.
  always @(posedge clk_in) begin
    ack_out <= take_in && irq_in && !ack_out;
    if (push_stb_in && push_item_in === 2'(push_cnt_out % 3)) begin
      push_cnt_out <= push_cnt_out + 1;
    end
    if (vec_stb_in && !hi_next) begin
      vec_lo_out <= vec_addr_in;
      hi_next <= 1'b1;
    end
    if (vec_stb_in && hi_next) begin
      hi_next <= 1'b0;
      if (vec_addr_in === vec_lo_out + 16'h0001) begin
        vec_cnt_out <= vec_cnt_out + 1;
      end
    end
  end
endmodule

// ===== tb/mpi_unit_bench.sv
// Self-checking bench of the interrupt unit driven over AHB-Lite.
`timescale 1ns/10ps
module mpi_unit_bench;
  import mpi_pkg::*;
  typedef struct packed {
    logic [13:0] ev;
    logic [13:0] en;
    logic software_break_instruction;
    logic dis;
    logic [15:0] vec;
    logic [13:0] rem;
  } mpi_row_s;
  mpi_row_s rows [0:5];
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hwrite = 1'b0, hready, hresp, software_break_instruction = 1'b0, take = 1'b0, ack, irq, pstb, vstb, intr;
  logic [13:0] ev = 14'h0000;
  logic [3:0] edge_sel;
  logic [1:0] pitem;
  logic [15:0] vaddr, vlo;
  int pcnt, vcnt, mismatches = 0, compares = 0, cycles = 0, n;

  mpi_unit i_mpi_unit (.MCLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .SRC_EVENT_IN(ev), .SOFTWARE_BREAK_INSTRUCTION_IN(software_break_instruction), .EDGE_SEL_OUT(edge_sel),
    .CORE_ACK_IN(ack), .CORE_IRQ_OUT(irq), .PUSH_STB_OUT(pstb), .PUSH_ITEM_OUT(pitem),
    .VEC_RD_STB_OUT(vstb), .VEC_ADDR_OUT(vaddr), .INT_OUT(intr));
  mpi_core_model i_mpi_core_model (.clk_in(clk), .irq_in(irq), .take_in(take),
    .push_stb_in(pstb), .push_item_in(pitem), .vec_stb_in(vstb), .vec_addr_in(vaddr),
    .ack_out(ack), .vec_lo_out(vlo), .push_cnt_out(pcnt), .vec_cnt_out(vcnt));

  // Free-running clock and a hang guard well beyond the few hundred cycles used.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One single word transfer; settled values are sampled half a cycle before each edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic ok;
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(negedge clk);
      ok = hready;
      @(posedge clk);
    end while (ok !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      ok = hready;
      rd = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic pulse(input logic [13:0] e, input logic b);
    @(posedge clk);
    ev <= e;
    software_break_instruction <= b;
    @(posedge clk);
    ev <= 14'h0000;
    software_break_instruction <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rows[0] = {14'h3000, 14'h3FFF, 1'b0, 1'b0, 16'hFFE0, 14'h2000};
    rows[1] = {14'h0021, 14'h0020, 1'b0, 1'b0, 16'hFFF0, 14'h0001};
    rows[2] = {14'h0003, 14'h0003, 1'b0, 1'b0, 16'hFFFA, 14'h0002};
    rows[3] = {14'h2000, 14'h2000, 1'b0, 1'b0, 16'hFFDE, 14'h0000};
    rows[4] = {14'h0010, 14'h0000, 1'b1, 1'b0, 16'hFFDC, 14'h0010};
    rows[5] = {14'h0002, 14'h0002, 1'b1, 1'b1, 16'hFFDC, 14'h0002};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("req", MPI_OFS_REQ, 32'h0);
    rdchk("ctrl", MPI_OFS_CTRL, 32'h1);
    chk("resp", 32'h0, {31'h0, hresp});
    $display("reset test done");
    // Each row: clear, mask, fire events, unmask unless the row keeps disable set, let the core take the winner.
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, MPI_OFS_REQ, 32'h0);
      bus(1'b1, MPI_OFS_EN, {18'h0, rows[i].en});
      rdchk("en", MPI_OFS_EN, {18'h0, rows[i].en});
      pulse(rows[i].ev, rows[i].software_break_instruction);
      if (!rows[i].dis) bus(1'b1, MPI_OFS_CTRL, 32'h0);
      n = vcnt;
      take <= 1'b1;
      for (int k = 0; k < 30 && vcnt == n; k++) @(posedge clk);
      take <= 1'b0;
      chk("vector", {16'h0, rows[i].vec}, {16'h0, vlo});
      chk("pushes", 32'(3 * (i + 1)), 32'(pcnt));
      chk("vector pairs", 32'(i + 1), 32'(vcnt));
      rdchk("ctrl", MPI_OFS_CTRL, 32'h1);
      rdchk("req", MPI_OFS_REQ, {18'h0, rows[i].rem});
      $display("row %0d done", i);
    end
    // The last row was won by the break: idle state, winner flagged as break.
    rdchk("state", MPI_OFS_STATE, 32'h8001);
    // Software cannot set a pending bit through the request register.
    bus(1'b1, MPI_OFS_REQ, 32'h3FFF);
    rdchk("req", MPI_OFS_REQ, 32'h2);
    // Interrupt line: masked, raised, cleared.
    chk("int", 32'h0, {31'h0, intr});
    bus(1'b1, MPI_OFS_IENA, 32'h3);
    // The enable lands on the edge that ends the write, so look once it has settled.
    @(negedge clk);
    chk("int", 32'h1, {31'h0, intr});
    rdchk("istat", MPI_OFS_ISTAT, 32'h3);
    bus(1'b1, MPI_OFS_ICLR, 32'h3);
    rdchk("istat", MPI_OFS_ISTAT, 32'h0);
    chk("int", 32'h0, {31'h0, intr});
    rdchk("unmapped", 8'h40, 32'h0);
    $display("interrupt test done");
    // Flipping an edge select raises that pin's request.
    bus(1'b1, MPI_OFS_REQ, 32'h0);
    bus(1'b1, MPI_OFS_EDGE, 32'h1);
    rdchk("req", MPI_OFS_REQ, 32'h10);
    chk("edge", 32'h1, {28'h0, edge_sel});
    // Reset in mid-run clears pending and enable bits.
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("req", MPI_OFS_REQ, 32'h0);
    rdchk("en", MPI_OFS_EN, 32'h0);
    $display("edge and reset test done");
    wrap_up();
  end
endmodule
